//--- core/pwr_rst_pkg.sv
// Package with register map, field positions, reset values and timing for the power/reset block.
package pwr_rst_pkg;
  // Register indices (byte address is four times the index).
  localparam logic [7:0] IDX_POWER_CONTROL  = 8'h87;
  localparam logic [7:0] IDX_RESET_CAUSE    = 8'h88;
  localparam logic [7:0] IDX_MONITOR_CTRL   = 8'h89;
  localparam logic [7:0] IDX_CORE_STATUS    = 8'h8A;
  // Power control fields.
  localparam int         PC_IDLE_BIT        = 0;
  localparam int         PC_STOP_BIT        = 1;
  localparam int         PC_FLAGS_LSB       = 2;
  localparam int         PC_FLAGS_MSB       = 7;
  localparam logic [7:0] POWER_CONTROL_RST  = 8'h00;
  // Reset cause fields.
  localparam int         RC_POWER_ON_BIT    = 1;
  localparam int         RC_MONITOR_SEL_BIT = 1;
  // Supply monitor control fields.
  localparam int         MC_ENABLE_BIT      = 7;
  localparam int         MC_STATUS_BIT      = 6;
  localparam int         MC_LEVEL_BIT       = 5;
  // Port and program counter reset values and the watchdog divider.
  localparam logic [7:0]  PORT_LATCH_RST    = 8'hFF;
  localparam logic [15:0] PC_RST            = 16'h0000;
  localparam logic [3:0]  WDT_DIVIDE        = 4'hC;
  // Power-on delay, the system clock and the read-data mask.
  localparam int          POWER_ON_DELAY_NS = 300_000;
  localparam int          SYS_CLK_NS        = 25;
  localparam int          POWER_ON_CYCLES   = POWER_ON_DELAY_NS / SYS_CLK_NS;
  localparam logic [31:0] SIG_MASK          = 32'h0000_00FF;
  // Reset sequencer states.
  typedef enum logic [3:0] {
    ST_POWER_ON = 4'b0001,
    ST_DELAY    = 4'b0010,
    ST_HELD     = 4'b0100,
    ST_RUN      = 4'b1000
  } seq_state_t;
endpackage

//--- core/sync_two_ff.sv
// Two-flip-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module sync_two_ff (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Level in and out.
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic firstQ;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      firstQ  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      firstQ  <= asyncIn;
      syncOut <= firstQ;
    end
  end
endmodule
`default_nettype wire

//--- core/power_mode_and_reset_control.sv
// Power-mode register, reset sequencing and supply-monitor reset control.
// Notes on behaviour
// [RULE1] Power control bits 7:2 are software flags, no hardware effect, reset zero.
// [RULE2] Writing one to bit 1 enters halt-all with oscillator stopped; reads zero.
// [RULE3] Writing one to bit 0 gates only the CPU clock; reads zero.
// [RULE4] Reset stops execution, resets registers, forces ports, disables interrupts and timers.
// [RULE5] Reset keeps data memory; stack pointer is still reinitialised.
// [RULE6] Port latches all ones, open-drain, weak pull-ups on during and after reset.
// [RULE7] Power-on and monitor resets drive the reset pin low while held.
// [RULE8] Leaving reset clears program counter, selects internal oscillator, fetches at zero.
// [RULE9] Leaving any reset enables the watchdog clocked at system clock over twelve.
// [RULE10] After supply rises, reset is held for the power-on delay.
// [RULE11] Power-on cause flag set after power-on reset, cleared by any other reset.
// [RULE12] Monitor enabled after power-on reset, kept unchanged across other resets.
// [RULE13] Supply below threshold drives reset pin low and holds the core in reset.
// [RULE14] Release from a monitor reset adds no power-on delay.
// [RULE15] Flash write or erase without high-level enabled monitor source causes flash-error reset.
// [RULE16] Software enables the monitor before selecting it as reset source.
// [RULE17] Software disables the monitor before changing level or trim.
// [RULE18] Power-on reset forces low threshold; high threshold may lock reset until power-on.
// [RULE19] Software should keep the monitor at the low threshold.
// [RULE20] Software treats data memory as undefined when power-on flag reads one.
// [RULE21] Mode entry happens only after the setting instruction completes.
// [RULE22] Enabled interrupt ends idle, clears idle bit, resumes the CPU.
// [RULE23] Halt-all mode ends only by an internal or external reset.
// [RULE24] Monitor control bit 5 selects low (0) or high (1) threshold.
// [RULE25] Internal reset asserts at once and releases on a clock edge.
`timescale 1ns/10ps
`default_nettype none
module power_mode_and_reset_control #(
  parameter int POWER_ON_CYCLES = pwr_rst_pkg::POWER_ON_CYCLES
) (
  // Clock and power-on reset from the supply detector.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Classic Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Analog and core inputs (asynchronous).
  input  wire logic        supplyAboveThreshold,
  input  wire logic        otherResetRequest,
  input  wire logic        flashWriteAttempt,
  input  wire logic        instructionDone,
  input  wire logic        interruptPending,
  // Reset pin as open-drain, active low.
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe,
  // Core controls.
  output logic             coreReset,
  output logic             cpuClockGate,
  output logic             oscillatorStop,
  output logic             idleWake,
  output logic             flashErrorReset,
  output logic             watchdogEnable,
  output logic [3:0]       watchdogDivide,
  output logic             internalOscSelect,
  output logic [15:0]      programCounterInit,
  output logic [7:0]       portLatchInit,
  output logic             portOpenDrain,
  output logic             weakPullupEnable,
  output logic             stackPointerReset,
  output logic             supplyMonitorEnable,
  output logic             supplyMonitorLevel
);
  logic supplyOk;
  logic otherReq;
  logic flashReq;
  logic instDone;
  logic irqPend;
  logic       pinLow;
  logic       pinInSync;
  logic [1:0] ownDrive_q;

  sync_two_ff uSupply (.sys_clk(sys_clk), .sys_rst(1'b0), .asyncIn(supplyAboveThreshold),
                       .syncOut(supplyOk));
  sync_two_ff uOther  (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(otherResetRequest),
                       .syncOut(otherReq));
  sync_two_ff uFlash  (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(flashWriteAttempt),
                       .syncOut(flashReq));
  sync_two_ff uInst   (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(instructionDone),
                       .syncOut(instDone));
  sync_two_ff uIrq    (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(interruptPending),
                       .syncOut(irqPend));
  sync_two_ff uPin    (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(resetPinIn),
                       .syncOut(pinInSync));
  // The pin echoes our own low drive through the synchroniser for two more cycles.
  // Masking that echo keeps a power-on or monitor reset from turning into a pin reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ownDrive_q <= 2'b11;
    end else begin
      ownDrive_q <= {ownDrive_q[0], resetPinOe};
    end
  end
  assign pinLow = ~pinInSync & ~resetPinOe & ~(|ownDrive_q);

  // Register state.
  logic [5:0]  softwareFlags_q;
  logic        idlePending_q;
  logic        stopPending_q;
  logic        idleActive_q;
  logic        stopActive_q;
  logic        powerOnCauseFlag_q;
  logic        monitorSelect_q;
  logic        supplyMonitorEnable_q;
  logic        supplyMonitorLevel_q;
  logic        flashError_q;
  pwr_rst_pkg::seq_state_t state_q;
  logic [31:0] delayCnt_q;

  // Bus decode.
  logic        access;
  logic        wrStb;
  logic [7:0]  regIdx;
  logic        hitPc;
  logic        hitRc;
  logic        hitMc;
  logic        hitSt;
  logic        mapped;
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign regIdx = wb_adr_i[9:2];
  assign hitPc  = (regIdx == pwr_rst_pkg::IDX_POWER_CONTROL);
  assign hitRc  = (regIdx == pwr_rst_pkg::IDX_RESET_CAUSE);
  assign hitMc  = (regIdx == pwr_rst_pkg::IDX_MONITOR_CTRL);
  assign hitSt  = (regIdx == pwr_rst_pkg::IDX_CORE_STATUS);
  assign mapped = (wb_adr_i[31:10] == 22'd0) & (hitPc | hitRc | hitMc | hitSt);
  assign wrStb  = access & wb_we_i & wb_sel_i[0] & mapped;

  // Reset request combination; the core reset leaves on one clock edge.
  logic anyReset;
  logic monitorTrip;
  assign monitorTrip = supplyMonitorEnable_q & monitorSelect_q & ~supplyOk;  // see [RULE13]
  assign anyReset    = otherReq | pinLow | flashError_q | monitorTrip;

  // Reset sequencer.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q    <= pwr_rst_pkg::ST_POWER_ON;
      delayCnt_q <= 32'd0;
    end else begin
      case (state_q)
        pwr_rst_pkg::ST_POWER_ON: begin
          delayCnt_q <= 32'd0;
          if (supplyOk) begin
            state_q <= pwr_rst_pkg::ST_DELAY;  // see [RULE10]
          end
        end
        pwr_rst_pkg::ST_DELAY: begin
          if (!supplyOk) begin
            state_q <= pwr_rst_pkg::ST_POWER_ON;
          end else if (delayCnt_q >= 32'(POWER_ON_CYCLES - 1)) begin
            state_q <= pwr_rst_pkg::ST_RUN;  // see [RULE10]
          end else begin
            delayCnt_q <= delayCnt_q + 32'd1;
          end
        end
        pwr_rst_pkg::ST_HELD: begin
          if (!anyReset) begin
            state_q <= pwr_rst_pkg::ST_RUN;  // see [RULE14]
          end
        end
        pwr_rst_pkg::ST_RUN: begin
          if (anyReset) begin
            state_q <= pwr_rst_pkg::ST_HELD;  // see [RULE23]
          end
        end
        default: state_q <= pwr_rst_pkg::ST_POWER_ON;
      endcase
    end
  end

  logic inPowerOn;
  assign inPowerOn = (state_q == pwr_rst_pkg::ST_POWER_ON) | (state_q == pwr_rst_pkg::ST_DELAY);
  // Assert at once on a request, release only through the registered state.
  assign coreReset = sys_rst | (state_q != pwr_rst_pkg::ST_RUN)
                     | anyReset;  // see [RULE25] [RULE4]

  // Pin driven low for power-on and supply-monitor resets only.
  assign resetPinOut = 1'b0;
  assign resetPinOe  = sys_rst | inPowerOn | monitorTrip;  // see [RULE7] [RULE13]

  // Software flags and mode bits.
  always_ff @(posedge sys_clk) begin
    if (coreReset) begin
      softwareFlags_q <= pwr_rst_pkg::POWER_CONTROL_RST[pwr_rst_pkg::PC_FLAGS_MSB:
                                                         pwr_rst_pkg::PC_FLAGS_LSB];
    end else if (wrStb && hitPc) begin  // see [RULE1]
      softwareFlags_q <= wb_dat_i[pwr_rst_pkg::PC_FLAGS_MSB:pwr_rst_pkg::PC_FLAGS_LSB];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (coreReset) begin
      idlePending_q <= 1'b0;
      stopPending_q <= 1'b0;
      idleActive_q  <= 1'b0;
      stopActive_q  <= 1'b0;
    end else begin
      if (wrStb && hitPc && wb_dat_i[pwr_rst_pkg::PC_IDLE_BIT]) begin
        idlePending_q <= 1'b1;
      end else if (idlePending_q && instDone) begin
        idlePending_q <= 1'b0;
      end
      if (wrStb && hitPc && wb_dat_i[pwr_rst_pkg::PC_STOP_BIT]) begin
        stopPending_q <= 1'b1;
      end else if (stopPending_q && instDone) begin
        stopPending_q <= 1'b0;
      end
      if (idlePending_q && instDone) begin
        idleActive_q <= 1'b1;  // see [RULE21] [RULE3]
      end else if (irqPend) begin
        idleActive_q <= 1'b0;  // see [RULE22]
      end
      if (stopPending_q && instDone) begin
        stopActive_q <= 1'b1;  // see [RULE21] [RULE2] [RULE23]
      end
    end
  end

  assign cpuClockGate   = idleActive_q | stopActive_q;
  assign oscillatorStop = stopActive_q;
  assign idleWake       = idleActive_q & irqPend;

  // Cause flag, monitor enable and level; power-on only for the last two.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      powerOnCauseFlag_q    <= 1'b1;
      supplyMonitorEnable_q <= 1'b1;  // see [RULE12]
      supplyMonitorLevel_q  <= 1'b0;  // see [RULE18]
    end else if (inPowerOn) begin
      powerOnCauseFlag_q    <= 1'b1;  // see [RULE11]
      supplyMonitorEnable_q <= 1'b1;
      supplyMonitorLevel_q  <= 1'b0;
    end else if (state_q == pwr_rst_pkg::ST_HELD) begin
      powerOnCauseFlag_q <= 1'b0;  // see [RULE11]
    end else if (wrStb && hitMc) begin
      supplyMonitorEnable_q <= wb_dat_i[pwr_rst_pkg::MC_ENABLE_BIT];
      supplyMonitorLevel_q  <= wb_dat_i[pwr_rst_pkg::MC_LEVEL_BIT];  // see [RULE24]
    end
  end

  // The source select is kept across non-power-on resets so a high level can lock reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || inPowerOn) begin
      monitorSelect_q <= 1'b0;
    end else if (wrStb && hitRc) begin
      monitorSelect_q <= wb_dat_i[pwr_rst_pkg::RC_MONITOR_SEL_BIT];  // see [RULE16]
    end
  end

  // Flash error: write or erase without the monitor at high level and selected.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || inPowerOn) begin
      flashError_q <= 1'b0;
    end else if (flashReq && !(supplyMonitorEnable_q && supplyMonitorLevel_q
                               && monitorSelect_q)) begin
      flashError_q <= 1'b1;  // see [RULE15]
    end else if (!flashReq) begin
      flashError_q <= 1'b0;
    end
  end
  assign flashErrorReset = flashError_q;

  // Reset-exit state, reset-time port and stack controls and monitor outputs handed to the core.
  assign watchdogEnable      = ~coreReset;  // see [RULE9]
  assign watchdogDivide      = pwr_rst_pkg::WDT_DIVIDE;
  assign internalOscSelect   = 1'b1;  // see [RULE8]
  assign programCounterInit  = pwr_rst_pkg::PC_RST;
  assign portLatchInit       = pwr_rst_pkg::PORT_LATCH_RST;  // see [RULE6]
  assign portOpenDrain       = coreReset;
  assign weakPullupEnable    = 1'b1;
  assign stackPointerReset   = coreReset;  // see [RULE5]
  assign supplyMonitorEnable = supplyMonitorEnable_q;
  assign supplyMonitorLevel  = supplyMonitorLevel_q;

  // Read mux and ack, one wait-free cycle.
  logic [31:0] rdData;
  always_comb begin
    rdData = 32'h0000_0000;
    if (hitPc) begin
      rdData[pwr_rst_pkg::PC_FLAGS_MSB:pwr_rst_pkg::PC_FLAGS_LSB] = softwareFlags_q;
    end else if (hitRc) begin
      rdData[pwr_rst_pkg::RC_POWER_ON_BIT] = powerOnCauseFlag_q;
    end else if (hitMc) begin
      rdData[pwr_rst_pkg::MC_ENABLE_BIT] = supplyMonitorEnable_q;
      rdData[pwr_rst_pkg::MC_STATUS_BIT] = supplyOk;
      rdData[pwr_rst_pkg::MC_LEVEL_BIT]  = supplyMonitorLevel_q;
    end else if (hitSt) begin
      rdData[3:0] = state_q;
      rdData[4]   = idleActive_q;
      rdData[5]   = stopActive_q;
    end
    if (!mapped) begin
      rdData = 32'h0000_0000;
    end
    rdData = rdData & pwr_rst_pkg::SIG_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? rdData : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

//--- test/pmrc_checker.sv
// Concurrent checks on the ports of the power-mode and reset controller.
`timescale 1ns/10ps
`default_nettype none
module pmrc_checker #(
  parameter int POWER_ON_CYCLES = pwr_rst_pkg::POWER_ON_CYCLES
) (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Bus.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Core side.
  input wire logic        interruptPending,
  input wire logic        resetPinOut,
  input wire logic        resetPinOe,
  input wire logic        coreReset,
  input wire logic        cpuClockGate,
  input wire logic        oscillatorStop,
  input wire logic        watchdogEnable,
  input wire logic [3:0]  watchdogDivide,
  input wire logic [7:0]  portLatchInit,
  input wire logic        portOpenDrain,
  input wire logic        weakPullupEnable,
  input wire logic        stackPointerReset,
  input wire logic        supplyMonitorEnable,
  input wire logic        supplyMonitorLevel
);
  // Counts cycles since the supply reset was released, saturating.
  logic [15:0] porCnt_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) porCnt_q <= 16'h0000;
    else if (porCnt_q != 16'hFFFF) porCnt_q <= porCnt_q + 16'h0001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack is not one cycle wide one clock after the request");
  chk_mode_bits_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 32'h0000_021C |-> wb_dat_o[1:0] == 2'b00)
    else $error("mode bits did not read back as zero");
  chk_pin_in_reset: assert property (
    resetPinOe |-> coreReset && !resetPinOut)
    else $error("reset pin driven outside the reset state");
  chk_watchdog_on: assert property (
    watchdogEnable == !coreReset && watchdogDivide == 4'hC)
    else $error("watchdog enable or divider wrong");
  chk_port_init: assert property (
    portOpenDrain == coreReset && portLatchInit == 8'hFF && weakPullupEnable
    && stackPointerReset == coreReset)
    else $error("port or stack initialisation wrong");
  chk_por_delay: assert property (
    $fell(coreReset) |-> porCnt_q >= POWER_ON_CYCLES)
    else $error("core left reset before the power-on delay");
  chk_stop_holds: assert property (
    $fell(oscillatorStop) |-> $past(coreReset))
    else $error("halt-all mode ended without a reset");
  chk_idle_wakes: assert property (
    cpuClockGate && !oscillatorStop && interruptPending |-> ##[1:6] !cpuClockGate)
    else $error("pending interrupt did not end idle");
  chk_por_monitor: assert property (
    disable iff (1'b0) $fell(sys_rst) |-> supplyMonitorEnable && !supplyMonitorLevel)
    else $error("monitor not enabled at low level after power-on");
endmodule
bind power_mode_and_reset_control pmrc_checker #(.POWER_ON_CYCLES(POWER_ON_CYCLES)) chk_u (
  .sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .interruptPending, .resetPinOut, .resetPinOe, .coreReset, .cpuClockGate, .oscillatorStop,
  .watchdogEnable, .watchdogDivide, .portLatchInit, .portOpenDrain, .weakPullupEnable,
  .stackPointerReset, .supplyMonitorEnable, .supplyMonitorLevel);
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the power-mode and reset controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int          PON  = 8;
  localparam logic [31:0] PC_A = {22'h0, pwr_rst_pkg::IDX_POWER_CONTROL, 2'b00};
  localparam logic [31:0] RC_A = {22'h0, pwr_rst_pkg::IDX_RESET_CAUSE, 2'b00};
  localparam logic [31:0] MC_A = {22'h0, pwr_rst_pkg::IDX_MONITOR_CTRL, 2'b00};
  logic        sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, supplyAboveThreshold;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, watchdogDivide;
  logic        otherResetRequest, flashWriteAttempt, instructionDone, interruptPending;
  logic        resetPinIn, resetPinOut, resetPinOe, coreReset, cpuClockGate, oscillatorStop;
  logic        idleWake, flashErrorReset, watchdogEnable, internalOscSelect, portOpenDrain;
  logic        weakPullupEnable, stackPointerReset, supplyMonitorEnable, supplyMonitorLevel;
  logic [15:0] programCounterInit;
  logic [7:0]  portLatchInit, flags;
  logic        woke;
  logic [31:0] expQ[$];
  int          failures, total_checks, n;
  // The pin has a pull-up and is pulled low only while the device drives it.
  assign resetPinIn = !(resetPinOe && !resetPinOut);
  power_mode_and_reset_control #(.POWER_ON_CYCLES(PON)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supplyAboveThreshold(supplyAboveThreshold),
    .otherResetRequest(otherResetRequest), .flashWriteAttempt(flashWriteAttempt),
    .instructionDone(instructionDone), .interruptPending(interruptPending),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .coreReset(coreReset), .cpuClockGate(cpuClockGate), .oscillatorStop(oscillatorStop),
    .idleWake(idleWake), .flashErrorReset(flashErrorReset), .watchdogEnable(watchdogEnable),
    .watchdogDivide(watchdogDivide), .internalOscSelect(internalOscSelect),
    .programCounterInit(programCounterInit), .portLatchInit(portLatchInit),
    .portOpenDrain(portOpenDrain), .weakPullupEnable(weakPullupEnable),
    .stackPointerReset(stackPointerReset), .supplyMonitorEnable(supplyMonitorEnable),
    .supplyMonitorLevel(supplyMonitorLevel));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One classic cycle; a read leaves its expected data for the monitor.
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                    input logic [31:0] exp);
    if (!we) expQ.push_back(exp);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse_done();
    @(posedge sys_clk);
    instructionDone <= 1'b1;
    @(posedge sys_clk);
    instructionDone <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, expQ.pop_front());
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    failures++;
    end_of_test();
  end
  initial begin
    {sys_rst, supplyAboveThreshold, wb_sel_i} = 6'b11_1111;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {otherResetRequest, flashWriteAttempt, instructionDone, interruptPending} = 4'h0;
    void'($urandom(32'h90ab));
    flags = 8'($urandom) & 8'hFC;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (n = 0; n < 100 && coreReset !== 1'b0; n++) tick();
    check(n >= PON && n <= PON + 6, 1);
    check({internalOscSelect, programCounterInit, resetPinOe}, 18'h2_0000);
    wb(0, PC_A, 0, 32'h0000_0000);
    wb(0, RC_A, 0, 32'h0000_0002);
    wb(0, MC_A, 0, 32'h0000_00C0);
    wb(0, 32'h0000_03FC, 0, 32'h0000_0000);
    wb(1, PC_A, {24'h0, flags} | 32'h0000_0001, 0);
    repeat (4) tick();
    check(cpuClockGate, 0);
    pulse_done();
    for (n = 0; n < 10 && cpuClockGate !== 1'b1; n++) tick();
    check({cpuClockGate, oscillatorStop}, 2'b10);
    wb(0, PC_A, 0, {24'h0, flags});
    @(posedge sys_clk);
    interruptPending <= 1'b1;
    woke = 1'b0;
    for (n = 0; n < 10 && cpuClockGate !== 1'b0; n++) begin
      tick();
      woke |= idleWake;
    end
    check({woke, cpuClockGate}, 2'b10);
    @(posedge sys_clk);
    interruptPending <= 1'b0;
    flashWriteAttempt <= 1'b1;
    for (n = 0; n < 10 && flashErrorReset !== 1'b1; n++) tick();
    check(flashErrorReset, 1);
    @(posedge sys_clk);
    flashWriteAttempt <= 1'b0;
    for (n = 0; n < 50 && (flashErrorReset !== 1'b0 || coreReset !== 1'b0); n++) tick();
    wb(1, MC_A, 32'h0000_0020, 0);
    wb(1, MC_A, 32'h0000_00A0, 0);
    wb(1, RC_A, 32'h0000_0002, 0);
    wb(1, PC_A, {24'h0, flags}, 0);
    @(posedge sys_clk);
    flashWriteAttempt <= 1'b1;
    repeat (8) tick();
    check(flashErrorReset, 0);
    @(posedge sys_clk);
    flashWriteAttempt <= 1'b0;
    supplyAboveThreshold <= 1'b0;
    repeat (3 * PON) tick();
    check({coreReset, resetPinOe, watchdogEnable}, 3'b110);
    @(posedge sys_clk);
    supplyAboveThreshold <= 1'b1;
    for (n = 0; n < 100 && coreReset !== 1'b0; n++) tick();
    check(n < PON, 1);
    wb(0, PC_A, 0, 32'h0000_0000);
    wb(0, RC_A, 0, 32'h0000_0000);
    wb(1, MC_A, 32'h0000_0000, 0);
    wb(1, PC_A, 32'h0000_0002, 0);
    pulse_done();
    @(posedge sys_clk);
    interruptPending <= 1'b1;
    repeat (10) tick();
    check(oscillatorStop, 1);
    @(posedge sys_clk);
    interruptPending <= 1'b0;
    otherResetRequest <= 1'b1;
    repeat (4) @(posedge sys_clk);
    otherResetRequest <= 1'b0;
    for (n = 0; n < 50 && coreReset !== 1'b0; n++) tick();
    check(oscillatorStop, 0);
    wb(0, MC_A, 0, 32'h0000_0040);
    wb(0, RC_A, 0, 32'h0000_0000);
    repeat (4) @(posedge sys_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
